/* File: key_output_pkg.sv */
// Constants shared by the key access output logic.
// Assumes a 50 MHz system clock and one active-low asynchronous reset.
package key_output_pkg;

  localparam int unsigned LEVEL_W = 4;
  localparam logic [3:0] LEVEL_ZERO = 4'h0;
  localparam logic [3:0] LEVEL_MAX = 4'hF;

  // Three colour codes for the front indicator.
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_YELLOW = 2'h2;

  // Debounce time applied to the key presence pin.
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned KEY_SETTLE_US = 100;
  localparam int unsigned KEY_SETTLE_CYC = KEY_SETTLE_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_KEY = 4'h2,
    ST_GRANT = 4'h4,
    ST_TRIP = 4'h8
  } out_state_t;

endpackage : key_output_pkg

/* File: pin_sync.sv */
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin is a slow level; a change is taken once stages 2 and 3
// agree, so stage 1 is seen by stage 2 alone.
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;
  logic level_q;

  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;

endmodule : pin_sync

/* File: key_access_parallel_output.sv */
// Parallel switched outputs of the key reader: strobe, access level,
// enable contact with overload latch-off, and front indicator colour.
// Assumes the key reader core supplies validity and level on
// this clock; presence and overload come from pins and are synchronised.
//
// Function
// - After power-up every switched output, strobe and data, is Low.
// - Strobe goes High only for a placed key with valid access code.
// - Access level 0 to 15 is shown unsigned on four outputs, High one.
// - Data weights are 1, 2, 4 and 8, first output least significant.
// - In the contact variant the enable contact closes once a key sits.
// - Overload above 50 mA opens the contact until key is replaced.
// - Front indicator lights once power is present.
// - Indicator is yellow while a functional key sits untripped in the adapter.
`timescale 1ns/10ps
module key_access_parallel_output #(
  parameter bit HAS_CONTACT = 1'b1,
  parameter int unsigned SETTLE_CYC = key_output_pkg::KEY_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Key reader core, same clock
  input wire logic code_valid_i,
  input wire logic [3:0] key_access_level_i,
  // Pins from the adapter
  input wire logic key_present_i,
  input wire logic contact_overload_i,
  // Switched outputs to the controller
  output logic strobe_o,
  output logic [3:0] data_o,
  output logic semiconductor_enable_contact_o,
  // Front indicator
  output logic [1:0] led_colour_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and presence debounce.

  logic present_sync;
  logic overload_sync;

  pin_sync u_present_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(key_present_i),
    .level_o(present_sync)
  );

  pin_sync u_overload_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(contact_overload_i),
    .level_o(overload_sync)
  );

  // Presence must hold steady before the key counts as placed, so a key
  // wobbling in the slot cannot pulse the contact.
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_d;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_q;
  logic placed_d;
  logic placed_q;

  always_comb begin
    settle_d = settle_q;
    placed_d = placed_q;
    if (present_sync == placed_q) begin
      settle_d = '0;
    end else if (settle_q == SETTLE_CYC[$bits(settle_q)-1:0]) begin
      settle_d = '0;
      placed_d = present_sync;
    end else begin
      settle_d = settle_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= '0;
      placed_q <= 1'b0;
    end else begin
      settle_q <= settle_d;
      placed_q <= placed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output state machine.

  key_output_pkg::out_state_t state_d;
  key_output_pkg::out_state_t state_q;
  logic strobe_d;
  logic strobe_q;
  logic [3:0] data_d;
  logic [3:0] data_q;
  logic contact_d;
  logic contact_q;
  logic [1:0] led_d;
  logic [1:0] led_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      key_output_pkg::ST_IDLE: begin
        if (placed_q) begin
          state_d = key_output_pkg::ST_KEY;
        end
      end
      key_output_pkg::ST_KEY, key_output_pkg::ST_GRANT: begin
        if (!placed_q) begin
          state_d = key_output_pkg::ST_IDLE;
        end else if (HAS_CONTACT && overload_sync) begin
          state_d = key_output_pkg::ST_TRIP;
        end else if (code_valid_i) begin
          state_d = key_output_pkg::ST_GRANT;
        end else begin
          state_d = key_output_pkg::ST_KEY;
        end
      end
      key_output_pkg::ST_TRIP: begin
        // The latch ends only on removal, never on the overload clearing.
        if (!placed_q) begin
          state_d = key_output_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = key_output_pkg::ST_IDLE;
      end
    endcase
  end

  // The level word is only driven under a grant or a trip with a valid code, so an invalid key never
  // leaks its level onto the controller inputs.
  always_comb begin
    strobe_d = (state_d == key_output_pkg::ST_GRANT);
    data_d = key_output_pkg::LEVEL_ZERO;
    if (state_d == key_output_pkg::ST_GRANT) begin
      data_d = key_access_level_i;
    end
    // The tripped contact stays open, but strobe and level remain valid.
    if (state_d == key_output_pkg::ST_TRIP && code_valid_i) begin
      strobe_d = 1'b1;
      data_d = key_access_level_i;
    end
    contact_d = HAS_CONTACT &&
                (state_d == key_output_pkg::ST_KEY ||
                 state_d == key_output_pkg::ST_GRANT);
    led_d = key_output_pkg::LED_GREEN;
    if (state_d == key_output_pkg::ST_GRANT) begin
      led_d = key_output_pkg::LED_YELLOW;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= key_output_pkg::ST_IDLE;
      strobe_q <= 1'b0;
      data_q <= key_output_pkg::LEVEL_ZERO;
      contact_q <= 1'b0;
      led_q <= key_output_pkg::LED_OFF;
    end else begin
      state_q <= state_d;
      strobe_q <= strobe_d;
      data_q <= data_d;
      contact_q <= contact_d;
      led_q <= led_d;
    end
  end

  assign strobe_o = strobe_q;
  assign data_o = data_q;
  assign semiconductor_enable_contact_o = contact_q;
  assign led_colour_o = led_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  strobe_needs_key_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_q |-> $past(placed_q) && $past(code_valid_i))
    else $error("strobe high without a valid placed key");

  data_zero_idle_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !strobe_q |-> data_q == key_output_pkg::LEVEL_ZERO)
    else $error("data driven without strobe");

  data_follows_level_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_q |-> data_q == $past(key_access_level_i))
    else $error("data word differs from granted level");

  contact_needs_key_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    contact_q |-> $past(placed_q) && HAS_CONTACT)
    else $error("contact closed without a key");

  trip_opens_contact_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    contact_q && overload_sync && placed_q |=> !contact_q)
    else $error("contact not opened on overload");

  trip_stays_open_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == key_output_pkg::ST_TRIP && placed_q |=> !contact_q)
    else $error("tripped contact reclosed with key still placed");

  removal_clears_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(placed_q) |=> !strobe_q && !contact_q &&
                        data_q == key_output_pkg::LEVEL_ZERO)
    else $error("outputs not cleared on key removal");

  led_lit_run_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> led_q != key_output_pkg::LED_OFF)
    else $error("indicator dark while running");

  led_yellow_grant_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_q == key_output_pkg::ST_GRANT) ==
    (led_q == key_output_pkg::LED_YELLOW))
    else $error("indicator colour disagrees with grant");

  grant_seen_c: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_q && data_q == key_output_pkg::LEVEL_MAX);

  trip_seen_c: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == key_output_pkg::ST_TRIP ##1 !placed_q);

  removal_seen_c: cover property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_q ##1 !strobe_q);

endmodule : key_access_parallel_output

/* File: plc_model.sv */
// Controller model: reads the strobe and contact outputs and drives its own enable.
// Assumes the adapter outputs settle well before each rising clock edge.
`timescale 1ns/10ps
module plc_model (
  // Clock and mode selection
  input wire logic clk_i,
  input wire logic mode_ok_i,
  // Switched outputs of the adapter
  input wire logic strobe_i,
  input wire logic contact_i,
  // Own enable output
  output logic plc_enable_output_o
);
  // A granted key alone is not enough; the operator mode must suit it.
  always_ff @(posedge clk_i) begin
    plc_enable_output_o <= strobe_i & contact_i & mode_ok_i;
  end
endmodule : plc_model

/* File: test_key_access_parallel_output.sv */
// Self-checking bench for the key access outputs and controller model.
// Assumes a short debounce count so that a key settles in a few cycles.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; \
  if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module test_key_access_parallel_output;
  typedef struct packed {logic [3:0] lvl; logic [3:0] dat;} row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic code_valid_i = 1'b0;
  logic [3:0] key_access_level_i = 4'h0;
  logic key_present_i = 1'b0;
  logic contact_overload_i = 1'b0;
  logic mode_ok = 1'b1;
  logic strobe_o;
  logic [3:0] data_o;
  logic semiconductor_enable_contact_o;
  logic [1:0] led_colour_o;
  logic plc_en;
  logic bare_contact;
  // Short filter for the bench. A key change shows after this many cycles:
  // four sync flops, the settle count plus one, and the output register.
  localparam int SETTLE = 4;
  localparam int PLACE_CYC = SETTLE + 6;
  int num_errors = 0;
  int cmp_count = 0;
  row_t rows [7] = '{'{4'h0, 4'h0}, '{4'h1, 4'h1}, '{4'h2, 4'h2},
    '{4'h4, 4'h4}, '{4'h8, 4'h8}, '{4'h7, 4'h7}, '{4'hF, 4'hF}};

  always #10 clk_i = ~clk_i;

  key_access_parallel_output #(.HAS_CONTACT(1'b1), .SETTLE_CYC(SETTLE)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .code_valid_i(code_valid_i),
    .key_access_level_i(key_access_level_i),
    .key_present_i(key_present_i),
    .contact_overload_i(contact_overload_i), .strobe_o(strobe_o),
    .data_o(data_o),
    .semiconductor_enable_contact_o(semiconductor_enable_contact_o),
    .led_colour_o(led_colour_o));

  plc_model i_plc (.clk_i(clk_i), .mode_ok_i(mode_ok), .strobe_i(strobe_o),
    .contact_i(semiconductor_enable_contact_o),
    .plc_enable_output_o(plc_en));

  // Variant without the contact: its contact output must never close.
  key_access_parallel_output #(.HAS_CONTACT(1'b0), .SETTLE_CYC(SETTLE))
    i_dut_bare (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .code_valid_i(code_valid_i),
    .key_access_level_i(key_access_level_i),
    .key_present_i(key_present_i),
    .contact_overload_i(contact_overload_i), .strobe_o(), .data_o(),
    .semiconductor_enable_contact_o(bare_contact), .led_colour_o());

  // Sums the outputs by their weights; an unknown bit stays unknown.
  function automatic logic [3:0] weigh(input logic [3:0] d);
    return d[0] * 4'h1 + d[1] * 4'h2 + d[2] * 4'h4 + d[3] * 4'h8;
  endfunction : weigh

  ////////////////////////////////////////////////////////////////////////////
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles

  // The filter fixes the delay, so the outcome is looked at exactly then;
  // a contact that is already open passes the check however slow the removal.
  task automatic place(input logic on);
    key_present_i = on;
    cycles(PLACE_CYC);
    `CHK("contact", on, semiconductor_enable_contact_o)
    `CHK("bare contact", 1'b0, bare_contact)
  endtask : place

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(3000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    cycles(8);
    `CHK("strobe", 1'b0, strobe_o)
    `CHK("data", 4'h0, data_o)
    `CHK("contact", 1'b0, semiconductor_enable_contact_o)
    rst_n_i = 1'b1;
    cycles(2);
    `CHK("led", key_output_pkg::LED_GREEN, led_colour_o)
    code_valid_i = 1'b1;
    key_access_level_i = 4'hF;
    cycles(3);
    `CHK("strobe", 1'b0, strobe_o)
    `CHK("data", 4'h0, data_o)
    code_valid_i = 1'b0;
    $display("test reset done");
    place(1'b1);
    `CHK("strobe", 1'b0, strobe_o)
    // Validity stands for a key whose reserve code bits were written OFF.
    foreach (rows[i]) begin
      code_valid_i = 1'b1;
      key_access_level_i = rows[i].lvl;
      cycles(3);
      `CHK("strobe", 1'b1, strobe_o)
      `CHK("data", rows[i].dat, data_o)
      `CHK("weight", rows[i].lvl, weigh(data_o))
      `CHK("led", key_output_pkg::LED_YELLOW, led_colour_o)
      `CHK("plc", 1'b1, plc_en)
    end
    mode_ok = 1'b0;
    cycles(2);
    `CHK("plc", 1'b0, plc_en)
    mode_ok = 1'b1;
    code_valid_i = 1'b0;
    cycles(2);
    `CHK("strobe", 1'b0, strobe_o)
    `CHK("data", 4'h0, data_o)
    $display("test levels done");
    code_valid_i = 1'b1;
    key_access_level_i = 4'h5;
    cycles(2);
    contact_overload_i = 1'b1;
    for (int i = 0; i < 12 && semiconductor_enable_contact_o !== 1'b0; i++)
      @(negedge clk_i);
    `CHK("contact", 1'b0, semiconductor_enable_contact_o)
    `CHK("strobe", 1'b1, strobe_o)
    `CHK("data", 4'h5, data_o)
    contact_overload_i = 1'b0;
    cycles(20);
    `CHK("contact", 1'b0, semiconductor_enable_contact_o)
    `CHK("plc", 1'b0, plc_en)
    $display("test overload done");
    place(1'b0);
    cycles(2);
    `CHK("strobe", 1'b0, strobe_o)
    `CHK("data", 4'h0, data_o)
    `CHK("led", key_output_pkg::LED_GREEN, led_colour_o)
    place(1'b1);
    `CHK("contact", 1'b1, semiconductor_enable_contact_o)
    $display("test removal done");
    rst_n_i = 1'b0;
    cycles(2);
    `CHK("strobe", 1'b0, strobe_o)
    `CHK("data", 4'h0, data_o)
    `CHK("contact", 1'b0, semiconductor_enable_contact_o)
    rst_n_i = 1'b1;
    cycles(PLACE_CYC);
    `CHK("contact", 1'b1, semiconductor_enable_contact_o)
    cycles(2);
    `CHK("strobe", 1'b1, strobe_o)
    `CHK("data", 4'h5, data_o)
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : test_key_access_parallel_output
